// ### bench/ccb_host_model.sv
// host controller model driving the serial register port
`timescale 1ns/1ps
module ccb_host_model (
  // clock
  input  wire logic core_clk,
  // serial pins toward the device
  output logic      sclk,
  output logic      cs_n,
  output logic      sdio_in,
  input  wire logic sdio_out,
  input  wire logic sdio_oe
);
  logic host_oe;
  logic host_bit;
  logic last_lvl;

  // wire level: device wins while it drives; a floating line shows the inverse of its last level
  assign sdio_in = sdio_oe ? sdio_out : (host_oe ? host_bit : ~last_lvl);

  // remembered level so a released line never looks like held data
  always @(posedge core_clk) begin
    last_lvl <= sdio_in;
  end

  initial begin
    sclk     = 1'b0;
    cs_n     = 1'b1;
    host_oe  = 1'b0;
    host_bit = 1'b0;
    last_lvl = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // one framed command: command byte then nb data bytes, bytes left-justified in wd and rd
  task automatic xfer(input logic [7:0] cmd, input int nb, input logic [31:0] wd, output logic [31:0] rd);
    logic [39:0] sh;
    int          i;
    sh = {cmd, wd};
    rd = 32'h00000000;
    @(posedge core_clk);
    cs_n <= 1'b0;
    wait_n(4);
    for (i = 0; i < 8 * (nb + 1); i++) begin
      host_oe  <= (i < 8) || !cmd[7];
      host_bit <= sh[39-i];
      wait_n(4);
      sclk <= 1'b1;
      wait_n(4);
      // read bits stand until the next fall, so sample at the end of the high phase
      if (i >= 8) rd[39-i] = sdio_in;
      sclk <= 1'b0;
    end
    wait_n(4);
    host_oe <= 1'b0;
    cs_n    <= 1'b1;
    wait_n(12);
  endtask
endmodule

// ### bench/ccb_top_tb.sv
// self-checking bench for the converter control word block
`timescale 1ns/1ps
module ccb_top_tb;
  import ccb_pkg::*;
  logic        core_clk;
  logic        nrst;
  logic        sclk;
  logic        cs_n;
  logic        sdio_in;
  logic        sdio_out;
  logic        sdio_oe;
  logic [23:0] data_value;
  logic [23:0] offset_constant;
  logic [23:0] full_scale_constant;
  logic [23:0] output_level;
  logic [1:0]  operating_mode_field;
  logic        resolution_select;
  logic        code_format_select;
  logic        filter_adaptive;
  logic        filter_fast;
  logic        output_connect;
  int          n_mismatch;
  int          samples_checked;
  int          cyc;

  ccb_top u_ccb_top (
    .core_clk            (core_clk),
    .nrst                (nrst),
    .sclk                (sclk),
    .cs_n                (cs_n),
    .sdio_in             (sdio_in),
    .sdio_out            (sdio_out),
    .sdio_oe             (sdio_oe),
    .data_value          (data_value),
    .offset_constant     (offset_constant),
    .full_scale_constant (full_scale_constant),
    .output_level        (output_level),
    .operating_mode_field(operating_mode_field),
    .resolution_select   (resolution_select),
    .code_format_select  (code_format_select),
    .filter_adaptive     (filter_adaptive),
    .filter_fast         (filter_fast),
    .output_connect      (output_connect)
  );

  ccb_host_model u_ccb_host_model (
    .core_clk(core_clk),
    .sclk    (sclk),
    .cs_n    (cs_n),
    .sdio_in (sdio_in),
    .sdio_out(sdio_out),
    .sdio_oe (sdio_oe)
  );

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic results();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // cut a hang short: the whole run needs well under this many cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // host always sets bit 13 of a control word it writes
  task automatic wr_cmr(input logic [15:0] w);
    logic [31:0] r;
    u_ccb_host_model.xfer(8'h24, 2, {w | 16'h2000, 16'h0000}, r);
  endtask

  task automatic rd2(input logic [7:0] cmd, output logic [15:0] v);
    logic [31:0] r;
    u_ccb_host_model.xfer(cmd, 2, 32'h00000000, r);
    v = r[31:16];
  endtask

  task automatic wr3(input logic [7:0] cmd, input logic [23:0] v);
    logic [31:0] r;
    u_ccb_host_model.xfer(cmd, 3, {v, 8'h00}, r);
  endtask

  task automatic t_reset();
    logic [15:0] v;
    chk("adaptive", 24'(filter_adaptive), 24'h000001);
    chk("fast", 24'(filter_fast), 24'h000000);
    chk("connect", 24'(output_connect), 24'h000001);
    chk("resolution", 24'(resolution_select), 24'h000000);
    chk("fmt", 24'(code_format_select), 24'h000000);
    chk("mode", 24'(operating_mode_field), 24'h000000);
    chk("level", output_level, 24'h800000);
    rd2(8'hA4, v);
    chk("ctrl reset", 24'(v), 24'h002000);
  endtask

  // every adaptive / inhibit pairing, with resolution and format riding along
  task automatic t_filter();
    logic [15:0] w;
    logic [15:0] v;
    for (int k = 0; k < 4; k++) begin
      w = {k[1], 15'h0000} | {11'h000, k[0], 4'h0} | {8'h00, k[0], 7'h00} | {10'h000, k[1], 5'h00};
      wr_cmr(w);
      chk("adaptive", 24'(filter_adaptive), 24'(!k[1] && !k[0]));
      chk("fast", 24'(filter_fast), 24'(k[1] && !k[0]));
      chk("resolution", 24'(resolution_select), 24'(k[0]));
      chk("fmt", 24'(code_format_select), 24'(k[1]));
      rd2(8'hA4, v);
      chk("ctrl back", 24'(v), 24'(w | 16'h2000));
    end
  endtask

  // decrement mode steers reads but never control-word writes
  task automatic t_direction();
    logic [15:0] v;
    wr_cmr(16'hDEF8);
    rd2(8'hA5, v);
    chk("ctrl dec read", 24'(v), 24'h00B8E0);
    wr_cmr(16'h0008);
    rd2(8'hA5, v);
    chk("ctrl dec write", 24'(v), 24'h000820);
    wr_cmr(16'h0000);
  endtask

  task automatic t_clears();
    wr3(8'h40, 24'h123456);
    wr3(8'h48, 24'hAABBCC);
    chk("data", data_value, 24'h123456);
    wr_cmr(16'h0240);
    chk("data clr", data_value, 24'h000000);
    chk("offset clr", offset_constant, 24'h000000);
    chk("fs clr", full_scale_constant, 24'h080000);
    chk("level twos", output_level, 24'h800000);
    wr3(8'h40, 24'h123456);
    wr_cmr(16'h0060);
    chk("data clr bin", data_value, 24'h000000);
    chk("level bin", output_level, 24'h000000);
  endtask

  // in sleep the clear bits are plain storage; leaving sleep with clear set still clears
  task automatic t_sleep();
    logic [15:0] v;
    wr3(8'h40, 24'h654321);
    wr3(8'h4C, 24'h7F0000);
    wr_cmr(16'h0242);
    chk("mode sleep", 24'(operating_mode_field), 24'h000002);
    chk("data kept", data_value, 24'h654321);
    chk("fs kept", full_scale_constant, 24'h7F0000);
    rd2(8'hA4, v);
    chk("ctrl sleep", 24'(v), 24'h002242);
    wr_cmr(16'h0040);
    chk("data wake clr", data_value, 24'h000000);
  endtask

  task automatic t_cal();
    wr_cmr(16'h0001);
    chk("mode cal", 24'(operating_mode_field), 24'h000001);
    chk("float", 24'(output_connect), 24'h000000);
    wr_cmr(16'h4001);
    chk("connected", 24'(output_connect), 24'h000001);
    wr_cmr(16'h0000);
    chk("mode normal", 24'(operating_mode_field), 24'h000000);
  endtask

  initial begin
    n_mismatch      = 0;
    samples_checked = 0;
    cyc             = 0;
    nrst            = 1'b0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge core_clk);
    t_reset();
    t_filter();
    t_direction();
    t_clears();
    t_sleep();
    t_cal();
    results();
  end
endmodule

// ### hdl/ccb_pkg.sv
// constants, field layout and types of the converter control word block
package ccb_pkg;
  // control word field positions
  localparam int unsigned BIT_ADAPT_OFF      = 15;
  localparam int unsigned BIT_CAL_CONNECT    = 14;
  localparam int unsigned BIT_CAL_CLEAR      = 9;
  localparam int unsigned BIT_RESOLUTION     = 7;
  localparam int unsigned BIT_DATA_CLEAR     = 6;
  localparam int unsigned BIT_FORMAT         = 5;
  localparam int unsigned BIT_SETTLE_INHIBIT = 4;
  localparam int unsigned BIT_STEP_DOWN      = 3;
  localparam int unsigned BIT_ORDER  = 2;
  localparam int unsigned MODE_HI    = 1;
  localparam int unsigned MODE_LO    = 0;

  // control word masks and reset values
  localparam logic [15:0] CTRL_RESET      = 16'h0000;
  localparam logic [15:0] CTRL_WR_MASK    = 16'hC2FF;
  localparam logic [15:0] CTRL_FIXED_ONES = 16'h2000;
  localparam logic [15:0] CTRL_RSV_MASK   = 16'h3D00;
  localparam logic [15:0] CTRL_SELF_CLEAR = 16'h0240;

  // operating modes
  typedef logic [1:0] ccb_mode_t;
  localparam ccb_mode_t MODE_NORMAL  = 2'h0;
  localparam ccb_mode_t MODE_SELFCAL = 2'h1;
  localparam ccb_mode_t MODE_SLEEP   = 2'h2;

  // data and calibration register values
  localparam logic [23:0] DIR_RESET = 24'h000000;
  localparam logic [23:0] DIR_CLEAR = 24'h000000;
  localparam logic [23:0] OFS_RESET  = 24'h000000;
  localparam logic [23:0] OFS_CLEAR  = 24'h000000;
  localparam logic [23:0] GAIN_RESET = 24'h800000;
  localparam logic [23:0] GAIN_CLEAR = 24'h080000;
  localparam logic [23:0] OT_SIGN    = 24'h800000;
  localparam logic [23:0] MASK16     = 24'hFFFF00;
  localparam logic [23:0] MASK20     = 24'hFFFFF0;

  // byte addresses of the serial register map
  localparam logic [3:0] A_DIR2 = 4'h0;
  localparam logic [3:0] A_DIR1 = 4'h1;
  localparam logic [3:0] A_DIR0 = 4'h2;
  localparam logic [3:0] A_CTRL1 = 4'h4;
  localparam logic [3:0] A_CTRL0 = 4'h5;
  localparam logic [3:0] A_OFS2  = 4'h8;
  localparam logic [3:0] A_OFS1  = 4'h9;
  localparam logic [3:0] A_OFS0  = 4'hA;
  localparam logic [3:0] A_GAIN2 = 4'hC;
  localparam logic [3:0] A_GAIN1 = 4'hD;
  localparam logic [3:0] A_GAIN0 = 4'hE;

  // command byte layout: read flag, byte count minus one, start address
  localparam int unsigned CMD_RD  = 7;
  localparam int unsigned CMD_NHI = 6;
  localparam int unsigned CMD_NLO = 5;
  localparam int unsigned CMD_AHI = 3;
  localparam logic [2:0]  BIT_LAST = 3'h7;

  typedef enum logic [1:0] {ST_CMD = 2'b00, ST_DATA = 2'b01} ccb_state_e;
endpackage

// ### hdl/ccb_sync.sv
// two-stage synchroniser for pins entering the core clock domain
`timescale 1ns/1ps
module ccb_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         nrst,
  // pins and synchronised copies
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  // one flop pair per bit; the first stage feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        meta_r[i]   <= RST_VAL[i];
        sync_out[i] <= RST_VAL[i];
      end else begin
        meta_r[i]   <= async_in[i];
        sync_out[i] <= meta_r[i];
      end
    end
  end
endmodule

// ### hdl/ccb_top.sv
// serial register port and control word of the delta-sigma output converter
`timescale 1ns/1ps
module ccb_top
  import ccb_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // serial port from the host
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic        sdio_in,
  output logic             sdio_out,
  output logic             sdio_oe,
  // data and calibration values toward the converter core
  output logic [23:0]      data_value,
  output logic [23:0]      offset_constant,
  output logic [23:0]      full_scale_constant,
  output logic [23:0]      output_level,
  // configuration toward the converter core
  output logic [1:0]       operating_mode_field,
  output logic             resolution_select,
  output logic             code_format_select,
  output logic             filter_adaptive,
  output logic             filter_fast,
  output logic             output_connect
);
  logic [2:0]  pin_raw;
  logic [2:0]  pin_s;
  logic        sclk_s;
  logic        cs_n_s;
  logic        sdi_s;
  logic        sclk_d_r;
  ccb_state_e  state_r;
  logic [2:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  logic [7:0]  tx_r;
  logic        rd_r;
  logic [1:0]  left_r;
  logic [3:0]  addr_r;
  logic        touch_r;
  logic        commit_r;
  logic [15:0] stage_r;
  logic [15:0] ctrl_r;
  logic [23:0] dir_r;
  logic [23:0] ofs_r;
  logic [23:0] gain_r;

  // byte reversal used for lsb-first shifting in both directions
  function automatic logic [7:0] rev8(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) r[i] = b[7 - i];
    return r;
  endfunction

  // sclk, chip select and data all come from the host's domain
  assign pin_raw = {sclk, cs_n, sdio_in};
  ccb_sync #(.W(3), .RST_VAL(3'h2)) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in (pin_raw),
    .sync_out (pin_s)
  );
  assign sclk_s = pin_s[2];
  assign cs_n_s = pin_s[1];
  assign sdi_s  = pin_s[0];

  // edge detection and byte framing
  logic       rise;
  logic       fall;
  logic       byte_done;
  logic       cmd_done;
  logic       data_done;
  logic       wr_data;
  logic       is_ctrl;
  logic       lsb_first;
  logic [7:0] byte_in;
  logic [7:0] wr_byte;
  logic [3:0] next_addr;
  logic [3:0] rd_addr;
  logic [15:0] ctrl_rd;
  logic [7:0] rd_src;
  logic       last_wr;
  assign rise      = sclk_s & ~sclk_d_r;
  assign fall      = ~sclk_s & sclk_d_r;
  assign byte_done = rise & ~cs_n_s & (bit_cnt_r == BIT_LAST);
  assign cmd_done  = byte_done & (state_r == ST_CMD);
  assign data_done = byte_done & (state_r == ST_DATA);
  assign wr_data   = data_done & ~rd_r;
  assign byte_in   = {shift_r[6:0], sdi_s};
  assign is_ctrl   = (addr_r == A_CTRL1) | (addr_r == A_CTRL0);
  assign lsb_first = ctrl_r[BIT_ORDER];
  assign wr_byte   = (lsb_first & ~is_ctrl) ? rev8(byte_in) : byte_in;
  // control word writes step up whatever the direction bit says
  assign next_addr = ((~rd_r & is_ctrl) | ~ctrl_r[BIT_STEP_DOWN]) ? addr_r + 4'h1
                                                                  : addr_r - 4'h1;
  assign last_wr   = wr_data & (left_r == 2'h0) & (is_ctrl | touch_r);

  // read side: fixed reserved bits are merged in here, never stored
  assign ctrl_rd = ctrl_r | CTRL_FIXED_ONES;
  assign rd_addr = cmd_done ? byte_in[CMD_AHI:0] : next_addr;
  always_comb begin
    unique case (rd_addr)
      A_DIR2:  rd_src = dir_r[23:16];
      A_DIR1:  rd_src = dir_r[15:8];
      A_DIR0:  rd_src = dir_r[7:0];
      A_CTRL1: rd_src = ctrl_rd[15:8];
      A_CTRL0: rd_src = ctrl_rd[7:0];
      A_OFS2:  rd_src = ofs_r[23:16];
      A_OFS1:  rd_src = ofs_r[15:8];
      A_OFS0:  rd_src = ofs_r[7:0];
      A_GAIN2: rd_src = gain_r[23:16];
      A_GAIN1: rd_src = gain_r[15:8];
      A_GAIN0: rd_src = gain_r[7:0];
      default: rd_src = 8'h00;
    endcase
  end

  // commit decode: effects judged on the mode being written
  logic        commit_ev;
  logic        new_normal;
  logic        new_sleep;
  logic        cal_zero;
  logic        data_zero;
  logic [15:0] ctrl_nxt;
  assign commit_ev  = commit_r & (fall | cs_n_s);
  assign new_normal = stage_r[MODE_HI:MODE_LO] == MODE_NORMAL;
  assign new_sleep  = stage_r[MODE_HI:MODE_LO] == MODE_SLEEP;
  assign cal_zero   = commit_ev & new_normal & stage_r[BIT_CAL_CLEAR];
  assign data_zero  = commit_ev & new_normal & stage_r[BIT_DATA_CLEAR];
  // clear bits only keep their value in sleep, so they read zero otherwise
  assign ctrl_nxt   = stage_r & CTRL_WR_MASK & (new_sleep ? 16'hFFFF : ~CTRL_SELF_CLEAR);

  // serial framing state
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_d_r  <= 1'b0;
      state_r   <= ST_CMD;
      bit_cnt_r <= 3'h0;
      shift_r   <= 8'h00;
      rd_r      <= 1'b0;
      left_r    <= 2'h0;
      addr_r    <= 4'h0;
      touch_r   <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      if (cs_n_s) begin
        state_r   <= ST_CMD;
        bit_cnt_r <= 3'h0;
      end else if (rise) begin
        shift_r   <= byte_in;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (cmd_done) begin
          state_r <= ST_DATA;
          rd_r    <= byte_in[CMD_RD];
          left_r  <= byte_in[CMD_NHI:CMD_NLO];
          addr_r  <= byte_in[CMD_AHI:0];
          touch_r <= 1'b0;
        end else if (data_done) begin
          addr_r  <= next_addr;
          touch_r <= touch_r | (~rd_r & is_ctrl);
          left_r  <= left_r - 2'h1;
          if (left_r == 2'h0) state_r <= ST_CMD;
        end
      end
    end
  end

  // read data: new bit put out on each falling clock while reading
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_r     <= 8'h00;
      sdio_out <= 1'b0;
      sdio_oe  <= 1'b0;
    end else begin
      sdio_oe <= rd_r & (state_r == ST_DATA) & ~cs_n_s;
      if (byte_done) begin
        tx_r <= lsb_first ? rev8(rd_src) : rd_src;
      end else if (fall) begin
        sdio_out <= tx_r[7];
        tx_r     <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // control word staging and commit; the staged copy starts from the live word
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage_r  <= CTRL_RESET;
      commit_r <= 1'b0;
      ctrl_r   <= CTRL_RESET;
    end else begin
      if (cmd_done) stage_r <= ctrl_r;
      if (wr_data && addr_r == A_CTRL1) stage_r[15:8] <= wr_byte;
      if (wr_data && addr_r == A_CTRL0) stage_r[7:0] <= wr_byte;
      if (commit_ev) begin
        commit_r <= 1'b0;
        ctrl_r   <= ctrl_nxt;
      end else if (last_wr) begin
        commit_r <= 1'b1;
      end
    end
  end

  // data and calibration registers; clears land on the commit cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dir_r <= DIR_RESET;
      ofs_r  <= OFS_RESET;
      gain_r <= GAIN_RESET;
    end else begin
      if (data_zero) dir_r <= DIR_CLEAR;
      if (cal_zero) begin
        ofs_r  <= OFS_CLEAR;
        gain_r <= GAIN_CLEAR;
      end
      if (wr_data) begin
        unique case (addr_r)
          A_DIR2:  dir_r[23:16] <= wr_byte;
          A_DIR1:  dir_r[15:8]  <= wr_byte;
          A_DIR0:  dir_r[7:0]   <= wr_byte;
          A_OFS2:  ofs_r[23:16]  <= wr_byte;
          A_OFS1:  ofs_r[15:8]   <= wr_byte;
          A_OFS0:  ofs_r[7:0]    <= wr_byte;
          A_GAIN2: gain_r[23:16] <= wr_byte;
          A_GAIN1: gain_r[15:8]  <= wr_byte;
          A_GAIN0: gain_r[7:0]   <= wr_byte;
          default: ;
        endcase
      end
    end
  end

  // converter-facing view; the output level drops low bits beyond the resolution
  logic [23:0] level_nxt;
  assign level_nxt = (ctrl_r[BIT_FORMAT] ? dir_r : dir_r ^ OT_SIGN) &
                     (ctrl_r[BIT_RESOLUTION] ? MASK20 : MASK16);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      data_value           <= DIR_RESET;
      offset_constant      <= OFS_RESET;
      full_scale_constant  <= GAIN_RESET;
      output_level         <= OT_SIGN;
      operating_mode_field <= MODE_NORMAL;
      resolution_select    <= 1'b0;
      code_format_select   <= 1'b0;
      filter_adaptive      <= 1'b1;
      filter_fast          <= 1'b0;
      output_connect       <= 1'b1;
    end else begin
      data_value           <= dir_r;
      offset_constant      <= ofs_r;
      full_scale_constant  <= gain_r;
      output_level         <= level_nxt;
      operating_mode_field <= ctrl_r[MODE_HI:MODE_LO];
      resolution_select    <= ctrl_r[BIT_RESOLUTION];
      code_format_select   <= ctrl_r[BIT_FORMAT];
      filter_adaptive      <= ~ctrl_r[BIT_SETTLE_INHIBIT] & ~ctrl_r[BIT_ADAPT_OFF];
      filter_fast          <= ~ctrl_r[BIT_SETTLE_INHIBIT] & ctrl_r[BIT_ADAPT_OFF];
      output_connect       <= ~((ctrl_r[MODE_HI:MODE_LO] == MODE_SELFCAL) & ~ctrl_r[BIT_CAL_CONNECT]);
    end
  end

  // checks
  sequence s_last_wr;
    last_wr;
  endsequence
  sequence s_data_zero;
    data_zero;
  endsequence
  property p_rsv_bits;
    @(posedge core_clk) disable iff (!nrst) (ctrl_rd & CTRL_RSV_MASK) == CTRL_FIXED_ONES;
  endproperty
  a_rsv_bits: assert property (p_rsv_bits) else $error("reserved control bits wrong");
  property p_cal_clear;
    @(posedge core_clk) disable iff (!nrst)
      cal_zero |=> ofs_r == OFS_CLEAR && gain_r == GAIN_CLEAR ##1 full_scale_constant == GAIN_CLEAR;
  endproperty
  a_cal_clear: assert property (p_cal_clear) else $error("calibration clear missed");
  property p_clear_bits_zero;
    @(posedge core_clk) disable iff (!nrst)
      ctrl_r[MODE_HI:MODE_LO] != MODE_SLEEP |-> !ctrl_r[BIT_CAL_CLEAR] && !ctrl_r[BIT_DATA_CLEAR];
  endproperty
  a_clear_bits_zero: assert property (p_clear_bits_zero) else $error("clear bit reads one outside sleep");
  property p_sleep_store;
    @(posedge core_clk) disable iff (!nrst)
      commit_ev && new_sleep |=> ctrl_r[BIT_CAL_CLEAR] == $past(stage_r[BIT_CAL_CLEAR]) && ofs_r == $past(ofs_r)
                                 && dir_r == $past(dir_r);
  endproperty
  a_sleep_store: assert property (p_sleep_store) else $error("sleep write had a side effect");
  property p_data_clear;
    @(posedge core_clk) disable iff (!nrst)
      s_data_zero |=> dir_r == DIR_CLEAR ##1 output_level == (code_format_select ? DIR_CLEAR : OT_SIGN);
  endproperty
  a_data_clear: assert property (p_data_clear) else $error("data clear level wrong");
  property p_filter;
    @(posedge core_clk) disable iff (!nrst) ctrl_r[BIT_SETTLE_INHIBIT] |=> !filter_adaptive && !filter_fast;
  endproperty
  a_filter: assert property (p_filter) else $error("filter active while inhibited");
  property p_cmr_inc;
    @(posedge core_clk) disable iff (!nrst) wr_data && is_ctrl |=> addr_r == $past(addr_r) + 4'h1;
  endproperty
  a_cmr_inc: assert property (p_cmr_inc) else $error("control write address not incremented");
  property p_dec;
    @(posedge core_clk) disable iff (!nrst)
      data_done && (rd_r || !is_ctrl) && ctrl_r[BIT_STEP_DOWN] |=> addr_r == $past(addr_r) - 4'h1;
  endproperty
  a_dec: assert property (p_dec) else $error("address not decremented");
  property p_commit;
    @(posedge core_clk) disable iff (!nrst) s_last_wr |=> (ctrl_r == $past(ctrl_r)) [*1] ##[0:8] commit_ev;
  endproperty
  a_commit: assert property (p_commit) else $error("control write not committed");
  property p_cal_hiz;
    @(posedge core_clk) disable iff (!nrst)
      ctrl_r[MODE_HI:MODE_LO] == MODE_SELFCAL && !ctrl_r[BIT_CAL_CONNECT] |=> !output_connect;
  endproperty
  a_cal_hiz: assert property (p_cal_hiz) else $error("output connected during calibration");
endmodule
